// *** rtl/rcg_run_mode_clock_gate.v ***
`timescale 1ns/1ps
// Notes on behaviour
// [R1] Register sits at offset 0x108 of base
// [R2] Set bit clocks unit; clear bit gates it
// [R3] Access to unclocked unit raises bus fault
// [R4] All enable bits reset to zero
// [R5] Bit 16 gates the USB controller
// [R6] Bit 13 gates the micro-DMA engine
// [R7] Bits 7..0 gate ports H..A
// [R8] Reserved bits read zero, ignore writes
// [R9] Software preserves reserved bits on updates
// [R10] Run register applies while running; others stored
// [R11] Auto gating selects sleep registers when sleeping
// [R12] Reads show state; writes take effect immediately
`include "rcg_regs.vh"
module rcg_run_mode_clock_gate #(
   parameter NUM_UNITS = 10
) (
   // Clock and reset
   input  wire                 hclk,
   input  wire                 hresetn,
   // AHB-Lite slave
   input  wire                 hsel,
   input  wire [31:0]          haddr,
   input  wire [1:0]           htrans,
   input  wire                 hwrite,
   input  wire [2:0]           hsize,
   input  wire [31:0]          hwdata,
   input  wire                 hready,
   output wire                 hreadyout,
   output wire                 hresp,
   output reg  [31:0]          hrdata,
   // Power state and scan enable
   input  wire                 sleep_req,
   input  wire                 deep_sleep_req,
   input  wire                 scan_enable,
   // Unit access monitor: one strobe per unit, same order as clocks
   input  wire [NUM_UNITS-1:0] unit_access,
   input  wire [31:0]          unit_access_addr,
   // Gated clocks, enables and bus fault
   output wire [NUM_UNITS-1:0] unit_clk,
   output wire [NUM_UNITS-1:0] unit_clk_en,
   output wire                 unit_bus_fault,
   // Interrupt
   output wire                 irq
);
   // Unit order: ports A..H, micro-DMA, USB
   reg  [31:0] run_mode_clock_gate_two_reg;
   reg  [31:0] sleep_mode_clock_gate_two_reg;
   reg  [31:0] deep_sleep_clock_gate_two_reg;
   reg  [31:0] run_mode_clock_config_reg;
   reg  [`RCG_IRQ_WIDTH-1:0] int_stat_reg;
   reg  [`RCG_IRQ_WIDTH-1:0] int_mask_reg;
   reg  [31:0] fault_addr_reg;
   reg         wr_pend_reg;
   reg  [11:0] wr_off_reg;
   reg  [31:0] active_gate;
   wire        xfer;
   wire        auto_clock_gating_select;
   wire [11:0] off;
   wire [NUM_UNITS-1:0] gate_bits;
   wire [NUM_UNITS-1:0] fault_vec;
   wire        fault_evt;
   wire        change_evt;
   wire [`RCG_IRQ_WIDTH-1:0] evt;
   wire [`RCG_IRQ_WIDTH-1:0] w1c;

   assign xfer = hsel & hready & htrans[1];
   assign off  = haddr[11:0];
   // Single-cycle data phase, never an error response
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   assign auto_clock_gating_select = run_mode_clock_config_reg[`RCG_ACG_BIT];

   // Sleep registers only used when auto gating is on
   always @* begin
      active_gate = run_mode_clock_gate_two_reg; // R10
      if (auto_clock_gating_select && deep_sleep_req) begin
         active_gate = deep_sleep_clock_gate_two_reg; // R11
      end else if (auto_clock_gating_select && sleep_req) begin
         active_gate = sleep_mode_clock_gate_two_reg; // R11
      end
   end

   assign gate_bits = {active_gate[`RCG_USB_BIT], active_gate[`RCG_DMA_BIT],
                       active_gate[`RCG_PORT_MSB:`RCG_PORT_LSB]}; // R5 R6 R7

   genvar g;
   generate
      for (g = 0; g < NUM_UNITS; g = g + 1) begin : g_unit
         rcg_gate_cell u_gate (
            .clk_in      (hclk),
            .enable      (gate_bits[g]),
            .test_enable (scan_enable),
            .clk_out     (unit_clk[g])
         ); // R2
         assign fault_vec[g] = unit_access[g] & ~gate_bits[g]; // R3
      end
   endgenerate

   assign unit_clk_en    = gate_bits;
   assign unit_bus_fault = |fault_vec; // R3
   assign fault_evt      = unit_bus_fault;
   assign change_evt     = wr_pend_reg && (wr_off_reg == `RCG_RUN_GATE_OFF) &&
                           (((hwdata & `RCG_GATE_MASK) ^ run_mode_clock_gate_two_reg) != 32'h0000_0000);
   assign evt = {change_evt, fault_evt};
   assign w1c = (wr_pend_reg && wr_off_reg == `RCG_INT_STAT_OFF) ? hwdata[`RCG_IRQ_WIDTH-1:0]
                                                                 : {`RCG_IRQ_WIDTH{1'b0}};
   assign irq = |(int_stat_reg & int_mask_reg);

   // Address phase capture
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         wr_off_reg  <= 12'h000;
      end else begin
         wr_pend_reg <= xfer & hwrite;
         wr_off_reg  <= off;
      end
   end

   // Register writes in the data phase
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         run_mode_clock_gate_two_reg   <= `RCG_GATE_RESET; // R4
         sleep_mode_clock_gate_two_reg <= `RCG_GATE_RESET;
         deep_sleep_clock_gate_two_reg <= `RCG_GATE_RESET;
         run_mode_clock_config_reg     <= `RCG_CFG_RESET;
         int_mask_reg                  <= {`RCG_IRQ_WIDTH{1'b0}};
      end else if (wr_pend_reg) begin
         case (wr_off_reg)
            `RCG_RUN_GATE_OFF:   run_mode_clock_gate_two_reg   <= hwdata & `RCG_GATE_MASK; // R8 R12
            `RCG_SLEEP_GATE_OFF: sleep_mode_clock_gate_two_reg <= hwdata & `RCG_GATE_MASK;
            `RCG_DEEP_GATE_OFF:  deep_sleep_clock_gate_two_reg <= hwdata & `RCG_GATE_MASK;
            `RCG_CLK_CFG_OFF:    run_mode_clock_config_reg     <= hwdata;
            `RCG_INT_MASK_OFF:   int_mask_reg <= hwdata[`RCG_IRQ_WIDTH-1:0];
            default: begin
            end
         endcase
      end
   end

   // Sticky status: a new event beats the clear
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         int_stat_reg   <= {`RCG_IRQ_WIDTH{1'b0}};
         fault_addr_reg <= 32'h0000_0000;
      end else begin
         int_stat_reg <= (int_stat_reg & ~w1c) | evt;
         if (fault_evt) begin
            fault_addr_reg <= unit_access_addr;
         end
      end
   end

   // Read data, registered so hrdata comes from a flop in the data phase
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (xfer && !hwrite) begin
         case (off)
            // Forward a run gate write still in its data phase so back-to-back reads see it; other offsets read the stored value
            `RCG_RUN_GATE_OFF:   hrdata <= (wr_pend_reg && wr_off_reg == `RCG_RUN_GATE_OFF) ?
                                           (hwdata & `RCG_GATE_MASK) : run_mode_clock_gate_two_reg; // R1 R12
            `RCG_SLEEP_GATE_OFF: hrdata <= sleep_mode_clock_gate_two_reg;
            `RCG_DEEP_GATE_OFF:  hrdata <= deep_sleep_clock_gate_two_reg;
            `RCG_CLK_CFG_OFF:    hrdata <= run_mode_clock_config_reg;
            `RCG_INT_STAT_OFF:   hrdata <= {{(32-`RCG_IRQ_WIDTH){1'b0}}, int_stat_reg};
            `RCG_INT_MASK_OFF:   hrdata <= {{(32-`RCG_IRQ_WIDTH){1'b0}}, int_mask_reg};
            `RCG_FAULT_ADDR_OFF: hrdata <= fault_addr_reg;
            default:             hrdata <= 32'h0000_0000;
         endcase
      end
   end
endmodule // rcg_run_mode_clock_gate

// *** rtl/rcg_regs.vh ***
`ifndef RCG_REGS_VH
`define RCG_REGS_VH
// System control base and register offsets
`define RCG_SYSCTL_BASE      32'h400F_E000
`define RCG_RUN_GATE_OFF     12'h108
`define RCG_SLEEP_GATE_OFF   12'h118
`define RCG_DEEP_GATE_OFF    12'h128
`define RCG_CLK_CFG_OFF      12'h060
`define RCG_INT_STAT_OFF     12'h300
`define RCG_INT_MASK_OFF     12'h304
`define RCG_FAULT_ADDR_OFF   12'h308
// Field positions
`define RCG_USB_BIT          16
`define RCG_DMA_BIT          13
`define RCG_PORT_LSB         0
`define RCG_PORT_MSB         7
`define RCG_ACG_BIT          27
// Writable bits: 16, 13, 7..0
`define RCG_GATE_MASK        32'h0001_20FF
`define RCG_GATE_RESET       32'h0000_0000
`define RCG_CFG_RESET        32'h0000_0000
// Interrupt status fields
`define RCG_IRQ_FAULT_BIT    0
`define RCG_IRQ_CHANGE_BIT   1
`define RCG_IRQ_WIDTH        2
`endif

// *** rtl/rcg_gate_cell.v ***
`timescale 1ns/1ps
// Glitch-free clock gate: enable taken on the falling edge
module rcg_gate_cell (
   // Clock
   input  wire clk_in,
   // Control
   input  wire enable,
   input  wire test_enable,
   // Gated clock
   output wire clk_out
);
   reg en_latch;

   // Flop on the low phase instead of a latch, so enable cannot glitch the high phase
   always @(negedge clk_in) begin
      en_latch <= enable | test_enable;
   end

   assign clk_out = clk_in & en_latch;
endmodule // rcg_gate_cell

// *** tb/rcg_gate_properties.sv ***
`timescale 1ns/1ps
module rcg_gate_properties #(parameter NUM_UNITS = 10) (
   // Bus side
   input logic                 hclk, hresetn, hsel, hwrite, hready,
   input logic [1:0]           htrans,
   input logic [31:0]          haddr, hwdata, hrdata,
   // Unit side
   input logic                 sleep_req, deep_sleep_req, scan_enable, unit_bus_fault, irq,
   input logic [NUM_UNITS-1:0] unit_access, unit_clk, unit_clk_en
);
   logic wa_reg, wr_reg, rd_reg;
   wire  take = hsel & hready & htrans[1];
   wire  hit  = haddr[11:0] == 12'h108;
   // Power modes and scan may legally override the run gating
   wire  run  = !scan_enable & !sleep_req & !deep_sleep_req;
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wa_reg <= 1'b0;
         wr_reg <= 1'b0;
         rd_reg <= 1'b0;
      end else begin
         wa_reg <= take & hwrite;
         wr_reg <= take & hwrite & hit;
         rd_reg <= take & !hwrite & hit;
      end
   end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   AST_FAULT: assert property (unit_bus_fault == |(unit_access & ~unit_clk_en))
      else $error("fault flag wrong");
   AST_RESET: assert property ($rose(hresetn) && run |-> unit_clk_en == '0 && !irq)
      else $error("enables not clear after reset");
   AST_WRITE: assert property (wr_reg && run |=>
      unit_clk_en == {$past(hwdata[16]), $past(hwdata[13]), $past(hwdata[7:0])}) else $error("write not applied");
   AST_RESV: assert property (rd_reg |-> (hrdata & 32'hFFFE_DF00) == '0)
      else $error("reserved bits not zero");
   AST_READ: assert property (rd_reg && run |-> {hrdata[16], hrdata[13], hrdata[7:0]} == unit_clk_en)
      else $error("read value wrong");
   AST_HOLD: assert property (run && !wr_reg |=> !run || $stable(unit_clk_en))
      else $error("enables moved without write");
   AST_CLK: assert property (@(negedge hclk) run && $stable(unit_clk_en) |-> unit_clk == unit_clk_en)
      else $error("gated clock wrong");
   AST_IRQ: assert property ($fell(irq) |-> $past(wa_reg))
      else $error("irq dropped without write");
   COV_WRITE: cover property (wr_reg);
   COV_FAULT: cover property (unit_bus_fault);
   COV_IRQ: cover property ($rose(irq));
endmodule // rcg_gate_properties
bind rcg_run_mode_clock_gate rcg_gate_properties #(.NUM_UNITS(NUM_UNITS)) u_props (.hclk, .hresetn, .hsel,
   .hwrite, .hready, .htrans, .haddr, .hwdata, .hrdata, .sleep_req, .deep_sleep_req, .scan_enable,
   .unit_bus_fault, .irq, .unit_access, .unit_clk, .unit_clk_en);

// *** tb/test_run_mode_clock_gate_two.sv ***
`timescale 1ns/1ps
`include "rcg_regs.vh"
module test_run_mode_clock_gate_two;
   logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
   logic [1:0]  htrans = 0;
   logic [31:0] haddr = 0, hwdata = 0, rd;
   logic [9:0]  acc = 0;
   logic        slp = 0, dslp = 0;
   wire         hready, hresp, irq, fault;
   wire  [31:0] hrdata;
   wire  [9:0]  uclk, en;
   int          bad_count = 0, n_compared = 0;
   always #5 hclk = ~hclk;
   rcg_run_mode_clock_gate u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata,
      .hready, .hreadyout(hready), .hresp(), .hrdata, .sleep_req(slp), .deep_sleep_req(dslp),
      .scan_enable(1'b0), .unit_access(acc), .unit_access_addr(haddr), .unit_clk(uclk), .unit_clk_en(en),
      .unit_bus_fault(fault), .irq);
   task automatic check(string w, logic [31:0] s, logic [31:0] e);
      n_compared++;
      if (s !== e) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", w, e, s);
      end
   endtask
   // Single word transfer; waits on hready, never assumes a latency
   task automatic bus(logic wr, logic [11:0] off, logic [31:0] wd);
      hsel <= 1'b1; htrans <= 2'b10; hwrite <= wr; haddr <= `RCG_SYSCTL_BASE + off;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0; htrans <= 2'b00; hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
      #1;
   endtask
   task automatic poke(logic [9:0] a);
      @(posedge hclk) acc <= a;
      #1 check("fault", 32'(fault), 32'(a != 0 && (a & en) == 0));
      @(posedge hclk) acc <= 10'h000;
      #1;
   endtask
   task automatic t_fields;
      int pos[10] = '{0, 1, 2, 3, 4, 5, 6, 7, 13, 16};
      check("reset irq", 32'(irq), 0);
      bus(0, `RCG_RUN_GATE_OFF, 0);
      check("reset value", rd, 0);
      for (int i = 0; i < 10; i++) begin
         bus(1, `RCG_RUN_GATE_OFF, 32'h0000_0001 << pos[i]);
         check("enable", 32'(en), 32'h0000_0001 << i);
         bus(0, `RCG_RUN_GATE_OFF, 0);
         check("readback", rd, 32'h0000_0001 << pos[i]);
      end
      bus(1, `RCG_RUN_GATE_OFF, 32'hFFFF_FFFF);
      bus(0, `RCG_RUN_GATE_OFF, 0);
      check("all set", rd, 32'h0001_20FF);
      bus(1, `RCG_RUN_GATE_OFF, 32'hFFFE_DF00);
      bus(0, `RCG_RUN_GATE_OFF, 0);
      check("reserved only", rd, 0);
   endtask
   task automatic t_fault;
      bus(1, `RCG_INT_MASK_OFF, 32'h0000_0001);
      poke(10'h008);
      check("irq set", 32'(irq), 1);
      bus(1, `RCG_INT_STAT_OFF, 32'h0000_0003);
      check("irq cleared", 32'(irq), 0);
      bus(1, `RCG_INT_MASK_OFF, 0);
      poke(10'h200);
      check("irq masked", 32'(irq), 0);
      bus(1, `RCG_INT_MASK_OFF, 32'h0000_0001);
      check("irq unmasked", 32'(irq), 1);
      bus(1, `RCG_INT_STAT_OFF, 32'h0000_0003);
      bus(1, `RCG_RUN_GATE_OFF, 32'h0000_0008);
      poke(10'h008);
      bus(1, 12'h0FC, 32'hFFFF_FFFF);
      bus(0, 12'h0FC, 0);
      check("unmapped", rd, 0);
   endtask
   task automatic t_clock;
      bus(0, `RCG_RUN_GATE_OFF, 0);
      bus(1, `RCG_RUN_GATE_OFF, rd | 32'h0001_0001);
      @(posedge hclk);
      #2 check("gated clocks", 32'(uclk), 32'h0000_0209);
   endtask
   task automatic t_sleep;
      bus(1, `RCG_SLEEP_GATE_OFF, 32'h0000_0004);
      bus(1, `RCG_DEEP_GATE_OFF, 32'h0000_2000);
      slp <= 1'b1;
      @(posedge hclk);
      #1 check("sleep no auto", 32'(en), 32'h0000_0209);
      bus(1, `RCG_CLK_CFG_OFF, 32'h0800_0000);
      check("sleep gate", 32'(en), 32'h0000_0004);
      dslp <= 1'b1;
      @(posedge hclk);
      #1 check("deep gate", 32'(en), 32'h0000_0100);
      slp <= 1'b0;
      dslp <= 1'b0;
      @(posedge hclk);
      #1 check("run again", 32'(en), 32'h0000_0209);
   endtask
   task automatic t_reset;
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      #1 check("reset enables", 32'(en), 0);
      hresetn <= 1'b1;
      @(posedge hclk);
      bus(0, `RCG_RUN_GATE_OFF, 0);
      check("reset readback", rd, 0);
   endtask
   task automatic complete_run;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_fields;
      t_fault;
      t_clock;
      t_sleep;
      t_reset;
      complete_run;
   end
   initial begin
      #20us;
      bad_count++;
      complete_run;
   end
endmodule // test_run_mode_clock_gate_two
